//--- verilog/dac_serial_slave.sv
// two-wire receive-only slave front end for an 8-bit dac
`timescale 1ns/10ps
// Notes on behaviour
// - slave address is seven bits, top three fixed at 010
// - two-strap variant fixes next two bits to one; four-strap uses all straps
// - watch for start plus matching address before taking any bytes
// - pull data line low in the ninth clock of each accepted byte
// - lone final command byte acts only through power-down and latch-clear
// - output byte loads the input latch picked by channel select
// - stop after a command byte in the frame copies every input latch to its output latch together
// - power-down bit powers down at stop; paired output byte still loads
// - powered down floats outputs while output latches keep new codes
// - power-down clear returns to normal drive at stop
// - every command byte overwrites the pending power-down setting
// - latch-clear empties input latches; outputs wait for stop
// - output byte after a latch-clear command is discarded
// - repeated start keeps input latches; only addressed device acts on stop
// - pending input data moves out on a later addressed frame with a command
// - stop inside a command byte drops it and ends the frame
// - stop inside an output byte keeps last command's power and clear bits
// - each channel holds an 8-bit code; one or two channels
module dac_serial_slave
  import dac_link_pkg::*;
#(
  parameter int NUM_CH     = 2,
  parameter int STRAP_BITS = 2
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // two-wire bus pins
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_n,
  // address straps
  input  wire logic [STRAP_BITS-1:0]  addr_strap,
  // dac side
  output logic [NUM_CH*DATA_W-1:0]    dac_code,
  output logic [NUM_CH-1:0]           dac_drive,
  output logic                        addressed
);

  localparam int CHW = $clog2(NUM_CH > 1 ? NUM_CH : 2);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_q_r;
  logic       sda_q_r;

  // two sync flops per pin plus a third delay flop; the second and third flops feed logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_q_r    <= scl_sync_r[1];
      sda_q_r    <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s && !scl_q_r;
  assign scl_fall  = !scl_s && scl_q_r;
  assign start_det = scl_s && scl_q_r && !sda_s && sda_q_r;
  assign stop_det  = scl_s && scl_q_r && sda_s && !sda_q_r;

  // ------------------------------------------------------------
  // own address
  // ------------------------------------------------------------
  function automatic logic addr_match(input logic [6:0] a, input logic [STRAP_BITS-1:0] s);
    logic [6:0] want;
    want = '0;
    if (STRAP_BITS >= 4) begin
      want = {ADDR_FIXED_HI, 4'(s)};
    end else begin
      want = {ADDR_FIXED_HI, ADDR_FIXED_MID, 2'(s)};
    end
    return a == want;
  endfunction

  // straps are static pins, brought in through two flops as well
  logic [STRAP_BITS-1:0] strap_m_r;
  logic [STRAP_BITS-1:0] strap_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_m_r <= '0;
      strap_r   <= '0;
    end else begin
      strap_m_r <= addr_strap;
      strap_r   <= strap_m_r;
    end
  end

  // ------------------------------------------------------------
  // bit engine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LS_IDLE,
    LS_ADDR,
    LS_BYTES,
    LS_IGNORE
  } link_state_e;

  link_state_e link_r;
  logic [3:0]  bitcnt_r;
  logic [7:0]  shift_r;
  logic        ack_r;
  logic        ack_pending_r;
  logic        next_is_cmd_r;
  logic        push_valid;
  logic        push_ready;
  link_word_s  push_word;
  logic        byte_done;

  // byte complete on the eighth rising edge
  assign byte_done = scl_rise && (bitcnt_r == 4'(BYTE_BITS - 1));

  // framing: start always restarts the address phase, stop returns to idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_r        <= LS_IDLE;
      bitcnt_r      <= '0;
      shift_r       <= '0;
      next_is_cmd_r <= 1'b1;
    end else if (start_det) begin
      link_r        <= LS_ADDR;
      bitcnt_r      <= '0;
      next_is_cmd_r <= 1'b1;
    end else if (stop_det) begin
      link_r        <= LS_IDLE;
      bitcnt_r      <= '0;
    end else if (link_r != LS_IDLE) begin
      if (scl_rise && bitcnt_r < BITCNT_ACK) begin
        shift_r <= {shift_r[6:0], sda_s};
      end
      if (scl_rise) begin
        bitcnt_r <= (bitcnt_r == BITCNT_ACK) ? '0 : bitcnt_r + 4'h1;
      end
      if (byte_done && link_r == LS_ADDR) begin
        // first seven bits are the address, the eighth the read/write bit;
        // read requests are not answered since the device takes writes only
        link_r <= (addr_match(shift_r[6:0], strap_r) && !sda_s)
                  ? LS_BYTES : LS_IGNORE;
      end
      if (byte_done && link_r == LS_BYTES) begin
        next_is_cmd_r <= !next_is_cmd_r;
      end
    end
  end

  // acknowledge: drive low for the ninth clock of each taken byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_r <= 1'b0;
    end else if (scl_fall && bitcnt_r == BITCNT_ACK) begin
      ack_r <= ((link_r == LS_BYTES) || (link_r == LS_ADDR && ack_pending_r)) && push_ready;
    end else if (scl_fall) begin
      ack_r <= 1'b0;
    end
  end

  // address byte accepted: remembered for the ack slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_pending_r <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_pending_r <= 1'b0;
    end else if (byte_done) begin
      ack_pending_r <= (link_r == LS_ADDR)
                       ? (addr_match(shift_r[6:0], strap_r) && !sda_s) : 1'b0;
    end
  end

  // pin drivers from flops; low enable means driving
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= !ack_r;
    end
  end

  // ------------------------------------------------------------
  // words into the fifo
  // ------------------------------------------------------------
  logic       addr_ok;
  assign addr_ok = (link_r == LS_BYTES);

  // full bytes, stop and repeated start become words; partial bytes vanish
  always_comb begin
    push_valid       = 1'b0;
    push_word.kind   = KIND_CMD;
    push_word.value  = {shift_r[6:0], sda_s};
    if (start_det && addr_ok) begin
      push_valid     = 1'b1;
      push_word.kind = KIND_RESTART;
    end else if (stop_det && addr_ok) begin
      push_valid     = 1'b1;
      push_word.kind = KIND_STOP;
    end else if (byte_done && addr_ok) begin
      push_valid     = 1'b1;
      push_word.kind = next_is_cmd_r ? KIND_CMD : KIND_DATA;
    end
  end

  logic       pop_valid;
  logic       pop_ready;
  logic [WORD_W-1:0] pop_bits;
  link_word_s pop_word;
  assign pop_word = link_word_s'(pop_bits);

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (WORD_W'(push_word)),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_bits)
  );

  // ------------------------------------------------------------
  // command decode on the drain side
  // ------------------------------------------------------------
  logic           pend_pdn_r;
  logic           pend_clr_r;
  logic [CHW-1:0] pend_ch_r;
  logic           have_cmd_r;
  logic           load_en;
  logic           clear_in;
  logic           commit;

  assign pop_ready = 1'b1;

  // each command overwrites the pending bits; reserved bits are not checked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_pdn_r <= 1'b0;
      pend_clr_r <= 1'b0;
      pend_ch_r  <= '0;
      have_cmd_r <= 1'b0;
    end else if (pop_valid) begin
      unique case (pop_word.kind)
        KIND_CMD: begin
          pend_pdn_r <= pop_word.value[CMD_POS_PDN];
          pend_clr_r <= pop_word.value[CMD_POS_LCLR];
          pend_ch_r  <= CHW'(pop_word.value[CMD_POS_CHSEL]) & CHW'(NUM_CH - 1);
          have_cmd_r <= 1'b1;
        end
        KIND_DATA: begin
          pend_clr_r <= 1'b0;
        end
        KIND_STOP, KIND_RESTART: begin
          have_cmd_r <= 1'b0;
          pend_clr_r <= 1'b0;
        end
      endcase
    end
  end

  assign clear_in = pop_valid && pop_word.kind == KIND_CMD
                    && pop_word.value[CMD_POS_LCLR];
  assign load_en  = pop_valid && pop_word.kind == KIND_DATA && !pend_clr_r;
  assign commit   = pop_valid && pop_word.kind == KIND_STOP && have_cmd_r;

  logic [NUM_CH*DATA_W-1:0] dac_code_w;
  logic [NUM_CH-1:0]        dac_drive_w;

  dac_latch_bank #(
    .NUM_CH (NUM_CH)
  ) u_bank (
    .clk           (clk),
    .rst_n         (rst_n),
    .load_en       (load_en),
    .load_ch       (pend_ch_r),
    .load_val      (pop_word.value),
    .clear_in      (clear_in),
    .commit        (commit),
    .pdn_at_commit (pend_pdn_r),
    .out_codes     (dac_code_w),
    .out_drive     (dac_drive_w)
  );

  // outputs registered once more so the top drives from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_code  <= '0;
      dac_drive <= '1;
      addressed <= 1'b0;
    end else begin
      dac_code  <= dac_code_w;
      dac_drive <= dac_drive_w;
      addressed <= addr_ok;
    end
  end

endmodule : dac_serial_slave

//--- verilog/dac_link_pkg.sv
// shared constants and types for the two-wire dac slave
package dac_link_pkg;

  // ------------------------------------------------------------
  // address layout
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_FIXED_HI  = 3'h2;   // top three address bits, 010
  localparam logic [1:0] ADDR_FIXED_MID = 2'h3;   // next two bits on the two-strap variant
  localparam int         ADDR_BITS      = 7;

  // ------------------------------------------------------------
  // command byte layout (bit positions)
  // ------------------------------------------------------------
  localparam int CMD_POS_RSV2  = 7;
  localparam int CMD_POS_RSV1  = 6;
  localparam int CMD_POS_RSV0  = 5;
  localparam int CMD_POS_LCLR  = 4;
  localparam int CMD_POS_PDN   = 3;
  localparam int CMD_POS_CHSEL = 0;

  // ------------------------------------------------------------
  // widths, counts and reset values
  // ------------------------------------------------------------
  localparam int         DATA_W       = 8;
  localparam int         BYTE_BITS    = 8;
  localparam int         FIFO_DEPTH   = 16;
  localparam logic [7:0] LATCH_RST    = 8'h00;
  localparam logic [3:0] BITCNT_ACK   = 4'h8;

  // ------------------------------------------------------------
  // received byte carried from the link to the fifo
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CMD,
    KIND_DATA,
    KIND_STOP,
    KIND_RESTART
  } byte_kind_e;

  typedef struct packed {
    byte_kind_e       kind;
    logic [7:0]       value;
  } link_word_s;

  localparam int WORD_W = $bits(link_word_s);

endpackage : dac_link_pkg

//--- verilog/word_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // honest flags straight from the count
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : word_fifo

//--- verilog/dac_latch_bank.sv
// per-channel input and output latches with power state
`timescale 1ns/10ps
module dac_latch_bank
  import dac_link_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // decoded actions
  input  wire logic              load_en,
  input  wire logic [$clog2(NUM_CH > 1 ? NUM_CH : 2)-1:0] load_ch,
  input  wire logic [DATA_W-1:0] load_val,
  input  wire logic              clear_in,
  input  wire logic              commit,
  input  wire logic              pdn_at_commit,
  // results
  output logic [NUM_CH*DATA_W-1:0] out_codes,
  output logic [NUM_CH-1:0]        out_drive
);

  logic [DATA_W-1:0] in_latch_r  [NUM_CH];
  logic [DATA_W-1:0] out_latch_r [NUM_CH];
  logic              powered_r;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // input latch: clear beats a load in the same cycle, a load later in the frame overwrites
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          in_latch_r[g] <= LATCH_RST;
        end else if (clear_in) begin
          in_latch_r[g] <= LATCH_RST;
        end else if (load_en && (int'(load_ch) == g)) begin
          in_latch_r[g] <= load_val;
        end
      end
      // output latch moves only at stop so channels change together
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          out_latch_r[g] <= LATCH_RST;
        end else if (commit) begin
          out_latch_r[g] <= in_latch_r[g];
        end
      end
      assign out_codes[g*DATA_W +: DATA_W] = out_latch_r[g];
      assign out_drive[g] = powered_r;
    end
  endgenerate

  // power state follows the last command byte at stop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powered_r <= 1'b1;
    end else if (commit) begin
      powered_r <= !pdn_at_commit;
    end
  end

endmodule : dac_latch_bank

//--- bench/dac_slave_props.sv
// concurrent checks on the ports of the dac serial slave
`timescale 1ns/10ps
module dac_slave_props
  import dac_link_pkg::*;
#(
  parameter int NUM_CH     = 2,
  parameter int STRAP_BITS = 2
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  // bus pins
  input wire logic                     scl_in,
  input wire logic                     sda_in,
  input wire logic                     sda_out,
  input wire logic                     sda_oe_n,
  input wire logic [STRAP_BITS-1:0]    addr_strap,
  // dac side
  input wire logic [NUM_CH*DATA_W-1:0] dac_code,
  input wire logic [NUM_CH-1:0]        dac_drive,
  input wire logic                     addressed
);
  // ----------------------------------------
  // bus event tracking and properties
  // ----------------------------------------
  logic       scl_q_r;
  logic       sda_q_r;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] since_stop_r;
  logic [7:0] since_start_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // last line levels; the clock must stand high across the data edge, so an
  // ack released just before a clock rise is not taken for a stop
  always_ff @(posedge clk) begin
    scl_q_r <= scl_in;
    sda_q_r <= sda_in;
  end
  assign bus_start = scl_in && scl_q_r && !sda_in && sda_q_r;
  assign bus_stop  = scl_in && scl_q_r && sda_in && !sda_q_r;

  // cycles since the last stop; saturates so a long idle stays large
  always_ff @(posedge clk) begin
    if (!rst_n || bus_stop) since_stop_r <= 8'h00;
    else if (since_stop_r != 8'hFF) since_stop_r <= since_stop_r + 8'h01;
  end

  // cycles since the last start or repeated start
  always_ff @(posedge clk) begin
    if (!rst_n) since_start_r <= 8'hFF;
    else if (bus_start) since_start_r <= 8'h00;
    else if (since_start_r != 8'hFF) since_start_r <= since_start_r + 8'h01;
  end

  a_reset_vals: assert property ($rose(rst_n) |-> sda_oe_n && !addressed
    && dac_code == '0 && &dac_drive) else $error("reset values wrong");
  a_code_at_stop: assert property ($changed(dac_code) |-> since_stop_r <= 8'h0C)
    else $error("codes changed away from a stop");
  a_drive_at_stop: assert property ($changed(dac_drive) |-> since_stop_r <= 8'h0C)
    else $error("drive changed away from a stop");
  a_ack_low_only: assert property (!sda_oe_n |-> !sda_out)
    else $error("enabled data pin not low");
  a_ack_bounded: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*4] ##[1:12] sda_oe_n)
    else $error("ack pulse length wrong");
  a_ack_when_addr: assert property ($fell(sda_oe_n) |-> ##[0:40] addressed)
    else $error("ack without address match");
  a_addr_after_start: assert property ($rose(addressed) |->
    since_start_r >= 8'h28 && since_start_r <= 8'h78) else $error("match not after start");
  a_addr_drops: assert property (bus_stop |-> ##[1:12] !addressed)
    else $error("still addressed after stop");

  // main scenarios reached
  c_code: cover property ($changed(dac_code));
  c_pdown: cover property ($fell(dac_drive[0]));
  c_ack: cover property ($fell(sda_oe_n));
endmodule : dac_slave_props

bind dac_serial_slave dac_slave_props #(.NUM_CH(NUM_CH), .STRAP_BITS(STRAP_BITS))
  dac_slave_props_inst (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap), .dac_code(dac_code),
  .dac_drive(dac_drive), .addressed(addressed));

//--- bench/bus_master_model.sv
// behavioural two-wire bus master driving the dac slave
`timescale 1ns/10ps
module bus_master_model (
  // pacing clock
  input  wire logic clk,
  // bus lines; sda_low pulls the data line low
  output logic      scl,
  input  wire logic sda_in,
  output logic      sda_low
);
  // ----------------------------------------
  // bus conditions and bytes
  // ----------------------------------------
  // idle: both lines released, clock stands still
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // a quarter of the 160 ns bus clock, on falling edges
  task automatic q;
    repeat (2) @(negedge clk);
  endtask : q

  // start or repeated start: data falls while clock is high
  task automatic start_c;
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start_c

  // stop: data rises while clock is high, clock then stands high
  task automatic stop_c;
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop_c

  // msb first; data only moves while the clock is low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sda_low = !b[7-i];
      q();
      scl = 1'b1;
      q();
      q();
      scl = 1'b0;
      q();
    end
  endtask : send_bits

  // whole byte plus the ninth clock; ack read in the middle of the high phase
  task automatic send_byte(input logic [7:0] b, output logic ack);
    send_bits(b, 8);
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    ack = !sda_in;
    q();
    scl = 1'b0;
    q();
  endtask : send_byte
endmodule : bus_master_model

//--- bench/test_dac_serial_slave.sv
// self-checking bench for the dac serial slave
`timescale 1ns/10ps
module test_dac_serial_slave;
  import dac_link_pkg::*;
  // ----------------------------------------
  // signals, instances and scenarios
  // ----------------------------------------
  localparam logic [6:0] MY_ADDR = {ADDR_FIXED_HI, ADDR_FIXED_MID, 2'h1};
  logic        clk;
  logic        rst_n;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe_n;
  logic        addressed;
  logic [15:0] dac_code;
  logic [1:0]  dac_drive;
  logic [1:0]  addr_strap;
  int          num_errors;
  int          checks;
  // pulled up unless the master or the device pulls low
  wire         sda = !(sda_low || (!sda_oe_n && !sda_out));

  dac_serial_slave #(.NUM_CH(2), .STRAP_BITS(2)) dac_serial_slave_inst (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap(addr_strap), .dac_code(dac_code),
    .dac_drive(dac_drive), .addressed(addressed));
  bus_master_model bus_master_model_inst (.clk(clk), .scl(scl), .sda_in(sda),
    .sda_low(sda_low));

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // compare tasks, one per kind of result
  task automatic check_code(input logic [15:0] exp);
    checks++;
    if (dac_code !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t code %h exp %h", $time, dac_code, exp);
    end
  endtask : check_code
  task automatic check_drive(input logic [1:0] exp);
    checks++;
    if (dac_drive !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t drive %b exp %b", $time, dac_drive, exp);
    end
  endtask : check_drive
  task automatic check_ack(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t ack %b exp %b", $time, got, exp);
    end
  endtask : check_ack

  // frame pieces; write bit always low
  task automatic open(input logic [6:0] a, input logic exp);
    logic ack;
    bus_master_model_inst.start_c();
    bus_master_model_inst.send_byte({a, 1'b0}, ack);
    check_ack(ack, exp);
  endtask : open
  task automatic send(input logic [7:0] b);
    logic ack;
    bus_master_model_inst.send_byte(b, ack);
    check_ack(ack, 1'b1);
  endtask : send
  // stop, then leave time for the outputs to settle
  task automatic close;
    bus_master_model_inst.stop_c();
    repeat (20) @(negedge clk);
  endtask : close

  // both channels loaded, then moved out together at stop
  task automatic t_dual;
    open(MY_ADDR, 1'b1);
    send(8'h00);
    send(8'hA5);
    send(8'h01);
    send(8'h3C);
    check_code(16'h0000);
    close();
    check_code(16'h3CA5);
  endtask : t_dual

  // wrong strap, middle or top bits, and a read request, are all ignored
  task automatic t_foreign;
    logic [6:0] bad [3] = '{7'h2E, 7'h25, 7'h6D};
    logic       ack;
    foreach (bad[i]) begin
      open(bad[i], 1'b0);
      bus_master_model_inst.send_bits(8'h00, 8);
      close();
      check_code(16'h3CA5);
    end
    bus_master_model_inst.start_c();
    bus_master_model_inst.send_byte({MY_ADDR, 1'b1}, ack);
    check_ack(ack, 1'b0);
    close();
    check_code(16'h3CA5);
  endtask : t_foreign

  // power down with a paired byte, then a lone command wakes it
  task automatic t_pdown;
    open(MY_ADDR, 1'b1);
    send(8'h09);
    send(8'h77);
    close();
    check_code(16'h77A5);
    check_drive(2'h0);
    open(MY_ADDR, 1'b1);
    send(8'h01);
    close();
    check_drive(2'h3);
    check_code(16'h77A5);
  endtask : t_pdown

  // only the last command's power bit counts
  task automatic t_pd_over;
    open(MY_ADDR, 1'b1);
    send(8'h08);
    send(8'h12);
    send(8'h01);
    send(8'h34);
    close();
    check_drive(2'h3);
    check_code(16'h3412);
  endtask : t_pd_over

  // latch clear drops the next byte; later pair loads normally
  task automatic t_clear;
    open(MY_ADDR, 1'b1);
    send(8'h10);
    send(8'hFF);
    send(8'h01);
    send(8'h42);
    check_code(16'h3412);
    close();
    check_code(16'h4200);
  endtask : t_clear

  // repeated start to another slave keeps pending data until later
  task automatic t_restart;
    open(MY_ADDR, 1'b1);
    send(8'h00);
    send(8'h11);
    open(7'h2E, 1'b0);
    close();
    check_code(16'h4200);
    open(MY_ADDR, 1'b1);
    send(8'h00);
    close();
    check_code(16'h4211);
  endtask : t_restart

  // stop inside a command byte, then inside an output byte
  task automatic t_early;
    open(MY_ADDR, 1'b1);
    send(8'h00);
    send(8'h55);
    bus_master_model_inst.send_bits(8'h08, 5);
    close();
    check_code(16'h4255);
    check_drive(2'h3);
    open(MY_ADDR, 1'b1);
    send(8'h08);
    bus_master_model_inst.send_bits(8'hC3, 4);
    close();
    check_code(16'h4255);
    check_drive(2'h0);
  endtask : t_early

  // verdict and end of run
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // main sequence: reset for three cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    addr_strap = 2'h1;
    num_errors = 0;
    checks = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check_code(16'h0000);
    check_drive(2'h3);
    t_dual();
    t_foreign();
    t_pdown();
    t_pd_over();
    t_clear();
    t_restart();
    t_early();
    report_and_stop();
  end

  // watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule : test_dac_serial_slave
